// file: pkg/via_pkg.sv
// via_pkg: constants for the vectored interrupt arbiter
// assumes one core clock domain and a plain register port
package via_pkg;
    // ------------------------------------------------------------------
    // sources and vectors
    // ------------------------------------------------------------------
    localparam int NUM_SRC = 13;
    localparam logic [15:0] ENTRY_ADDR = 16'h00FF;
    localparam logic [7:0] VEC_BASE = 8'hE0;
    localparam logic [7:0] VEC_TRAP = 8'hFE;
    localparam logic [7:0] VEC_DEFAULT = 8'hE0;
    localparam int ACK_CYCLES = 7;
    // ------------------------------------------------------------------
    // register map (byte offsets)
    // ------------------------------------------------------------------
    localparam logic [3:0] REG_ENABLE = 4'h0;
    localparam logic [3:0] REG_PENDING = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam int ST_GIE_BIT = 0;
    localparam int ST_TRAP_BIT = 1;
    localparam int ST_ACK_BIT = 2;
    typedef enum logic [1:0]
    {
        VIA_IDLE = 2'b00,
        VIA_ACK = 2'b01
    } via_state_t;
endpackage : via_pkg

// file: rtl/via_arbiter.sv
// via_arbiter: interrupt pending/enable, acknowledge sequencing and
// vector-select arbitration for the core.
// assumes core control strobes are synchronous to sys_clk_in.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
module via_arbiter
    import via_pkg::*;
#(
    parameter int N_SRC = via_pkg::NUM_SRC
)
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    // interrupt sources, one-cycle events, source index 0 ranks highest
    input wire logic [N_SRC-1:0] src_event_in,
    // core sequencer
    input wire logic instr_start_in,
    input wire logic instr_skip_in,
    input wire logic trap_opcode_in,
    input wire logic clear_trap_pending_instr_in,
    input wire logic return_from_interrupt_in,
    input wire logic vector_select_instr_in,
    input wire logic [15:0] vis_pc_in,
    input wire logic [15:0] ret_addr_in,
    input wire logic [15:0] pop_addr_in,
    input wire logic [7:0] vec_hi_byte_in,
    input wire logic [7:0] vec_lo_byte_in,
    input wire logic boot_rom_exec_in,
    // processor status word global enable write
    input wire logic psw_wr_in,
    input wire logic psw_gie_in,
    // register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    // core outputs
    output logic ack_start_out,
    output logic ack_busy_out,
    output logic push_out,
    output logic [15:0] push_addr_out,
    output logic pc_load_out,
    output logic [15:0] pc_value_out,
    output logic [15:0] table_addr_out,
    output logic global_int_enable_out,
    output logic trap_pending_flag_out
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [N_SRC-1:0] enable_q;
    logic [N_SRC-1:0] pending_q;
    logic gie_q;
    logic trap_q;
    via_state_t state_q;
    logic [2:0] ack_cnt_q;
    logic [N_SRC-1:0] active;
    logic take;
    logic [7:0] vis_byte;
    logic [15:0] tbl_base;
    logic wr_en;
    logic wr_pend;

    localparam logic [2:0] ACK_LAST = 3'(ACK_CYCLES - 1);

    assign wr_en = reg_wr_in && (reg_addr_in == REG_ENABLE);
    assign wr_pend = reg_wr_in && (reg_addr_in == REG_PENDING);
    assign active = enable_q & pending_q;

    // ------------------------------------------------------------------
    // enables and pending flags
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            enable_q <= '0;
        else if (wr_en)
            enable_q <= reg_wdata_in[N_SRC-1:0];
    end

    genvar gi;
    generate
        for (gi = 0; gi < N_SRC; gi++)
        begin : g_pend
            always_ff @(posedge sys_clk_in or negedge rstn_in)
            begin
                if (!rstn_in)
                    pending_q[gi] <= 1'b0;
                else if (src_event_in[gi])
                    pending_q[gi] <= 1'b1; // set beats clear
                else if (wr_pend)
                    pending_q[gi] <= reg_wdata_in[gi];
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // acknowledge decision
    // ------------------------------------------------------------------
    // boot ROM masks the request but not the global enable
    assign take = instr_start_in && !instr_skip_in && gie_q && !trap_q
        && !boot_rom_exec_in && (|active) && (state_q == VIA_IDLE)
        && !return_from_interrupt_in;

    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            gie_q <= 1'b0;
        else if (take)
            gie_q <= 1'b0;
        else if (return_from_interrupt_in)
            gie_q <= 1'b1;
        else if (psw_wr_in)
            gie_q <= psw_gie_in;
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            trap_q <= 1'b0;
        else if (trap_opcode_in)
            trap_q <= 1'b1;
        else if (clear_trap_pending_instr_in)
            trap_q <= 1'b0;
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            state_q <= VIA_IDLE;
            ack_cnt_q <= 3'h0;
        end
        else
        begin
            case (state_q)
                VIA_IDLE:
                    if (take)
                    begin
                        state_q <= VIA_ACK;
                        ack_cnt_q <= 3'h1;
                    end
                VIA_ACK:
                    if (ack_cnt_q == ACK_LAST)
                        state_q <= VIA_IDLE;
                    else
                        ack_cnt_q <= ack_cnt_q + 3'h1;
                default:
                    state_q <= VIA_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // vector arbitration
    // ------------------------------------------------------------------
    // index 0 ranks highest; slot FA down to E0 with FC and F0 reserved
    function automatic logic [7:0] slot_of(input int idx);
        int s;
        begin
            s = (idx < 5) ? (8'hFA - 2 * idx) : (8'hEE - 2 * (idx - 5));
            slot_of = 8'(s);
        end
    endfunction : slot_of

    always_comb
    begin
        vis_byte = VEC_DEFAULT;
        for (int i = N_SRC - 1; i >= 0; i--)
            if (active[i])
                vis_byte = slot_of(i);
        if (trap_q)
            vis_byte = VEC_TRAP;
    end

    // last byte of a block points the table into the next block
    assign tbl_base = (vis_pc_in[7:0] == 8'hFF) ?
        (vis_pc_in + 16'h0100) : vis_pc_in;

    // ------------------------------------------------------------------
    // outputs to the core
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            ack_start_out <= 1'b0;
            push_out <= 1'b0;
            push_addr_out <= 16'h0000;
            pc_load_out <= 1'b0;
            pc_value_out <= 16'h0000;
            table_addr_out <= 16'h0000;
        end
        else
        begin
            ack_start_out <= take;
            push_out <= take;
            pc_load_out <= 1'b0;
            if (take)
                push_addr_out <= ret_addr_in;
            if (state_q == VIA_ACK && ack_cnt_q == ACK_LAST)
            begin
                pc_load_out <= 1'b1;
                pc_value_out <= ENTRY_ADDR;
            end
            else if (return_from_interrupt_in)
            begin
                pc_load_out <= 1'b1;
                pc_value_out <= pop_addr_in;
            end
            else if (vector_select_instr_in)
            begin
                pc_load_out <= 1'b1;
                pc_value_out <= {1'b0, vec_hi_byte_in[6:0],
                    vec_lo_byte_in};
                table_addr_out <= {tbl_base[15:8], vis_byte};
            end
        end
    end

    assign ack_busy_out = (state_q == VIA_ACK);
    assign global_int_enable_out = gie_q;
    assign trap_pending_flag_out = trap_q;

    // ------------------------------------------------------------------
    // register read
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            reg_rdata_out <= 32'h0000_0000;
        else if (!reg_rd_in)
            reg_rdata_out <= 32'h0000_0000;
        else if (reg_addr_in == REG_ENABLE)
            reg_rdata_out <= 32'(enable_q);
        else if (reg_addr_in == REG_PENDING)
            reg_rdata_out <= 32'(pending_q);
        else if (reg_addr_in == REG_STATUS)
            reg_rdata_out <= 32'({ack_busy_out, trap_q, gie_q});
        else
            reg_rdata_out <= 32'h0000_0000;
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_take;
        take;
    endsequence

    sequence s_entry;
        ##(ACK_CYCLES) (pc_load_out && pc_value_out == ENTRY_ADDR);
    endsequence

    property p_ack_entry;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        s_take |-> s_entry;
    endproperty
    a_ack_entry: assert property (p_ack_entry)
        else $error("entry load not seven cycles after acknowledge");

    property p_gie_clear;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        take |=> !gie_q && ack_busy_out;
    endproperty
    a_gie_clear: assert property (p_gie_clear)
        else $error("global enable not cleared on acknowledge");

    property p_trap_blocks;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        trap_q |-> !take;
    endproperty
    a_trap_blocks: assert property (p_trap_blocks)
        else $error("maskable taken during trap service");

    property p_boot_blocks;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        boot_rom_exec_in && !psw_wr_in && !return_from_interrupt_in
            |=> gie_q == $past(gie_q) && !ack_start_out;
    endproperty
    a_boot_blocks: assert property (p_boot_blocks)
        else $error("boot ROM execution disturbed interrupts");

    property p_return_from_interrupt;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        return_from_interrupt_in && !take
            |=> gie_q && pc_load_out && pc_value_out == $past(pop_addr_in);
    endproperty
    a_return_from_interrupt: assert property (p_return_from_interrupt)
        else $error("return did not restore enable and address");

    property p_pend_hold;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (|pending_q) && !wr_pend |=> (pending_q & $past(pending_q))
            == $past(pending_q);
    endproperty
    a_pend_hold: assert property (p_pend_hold)
        else $error("pending flag dropped without software clear");

    property p_trap_vec;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        vector_select_instr_in && trap_q |=> table_addr_out[7:0] == VEC_TRAP;
    endproperty
    a_trap_vec: assert property (p_trap_vec)
        else $error("trap did not win arbitration");

    property p_default_vec;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        vector_select_instr_in && !trap_q && active == '0
            |=> table_addr_out[7:0] == VEC_DEFAULT;
    endproperty
    a_default_vec: assert property (p_default_vec)
        else $error("default slot not used");

    property p_top_vec;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        vector_select_instr_in && !trap_q && active[0]
            |=> table_addr_out[7:0] == 8'hFA;
    endproperty
    a_top_vec: assert property (p_top_vec)
        else $error("highest maskable source not chosen");

    property p_ack_push;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        take |=> push_out && push_addr_out == $past(ret_addr_in);
    endproperty
    a_ack_push: assert property (p_ack_push)
        else $error("return address not pushed on acknowledge");

    property p_psw_gie;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        psw_wr_in && !take && !return_from_interrupt_in
            |=> gie_q == $past(psw_gie_in);
    endproperty
    a_psw_gie: assert property (p_psw_gie)
        else $error("status word write did not reach global enable");

    property p_trap_hold;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        trap_q && !clear_trap_pending_instr_in |=> trap_q;
    endproperty
    a_trap_hold: assert property (p_trap_hold)
        else $error("trap flag dropped without its clear instruction");

    property p_pend_set;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        src_event_in != '0 |=> (pending_q & $past(src_event_in))
            == $past(src_event_in);
    endproperty
    a_pend_set: assert property (p_pend_set)
        else $error("source event did not set its pending flag");
endmodule : via_arbiter

// file: bench/via_core_model.sv
// via_core_model: instruction stream of the core seen by the arbiter
// assumes the bench gates it with run_in while it drives other strobes
`timescale 1ns/10ps
module via_core_model
#(
    // return address pushed on take, arbitrary value
    parameter logic [15:0] RET_ADDR = 16'h0234
)
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    // bench controls
    input wire logic run_in,
    input wire logic skip_in,
    input wire logic busy_in,
    // instruction stream
    output logic instr_start_out,
    output logic instr_skip_out,
    output logic [15:0] ret_addr_out
);
    logic [1:0] phase_q;
    assign ret_addr_out = RET_ADDR;
    // one instruction every four cycles, held off during acknowledge
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            phase_q <= 2'h0;
            instr_start_out <= 1'b0;
            instr_skip_out <= 1'b0;
        end
        else
        begin
            phase_q <= phase_q + 2'h1;
            instr_start_out <= run_in && !busy_in && phase_q == 2'h0;
            instr_skip_out <= skip_in && phase_q == 2'h0;
        end
    end
endmodule : via_core_model

// file: bench/testbench.sv
// testbench: sequences of register and core strobe calls for via_arbiter
// assumes via_core_model supplies instruction starts
`timescale 1ns/10ps
module testbench;
    import via_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, run = 1'b0, skip = 1'b0, boot = 1'b0;
    logic gie_w = 1'b0, wr_s = 1'b0, rd_s = 1'b0, st, sk, busy, ack, pl;
    logic [4:0] strb = 5'h00;
    logic [12:0] src = 13'h0000;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [15:0] vpc = 16'h0, pop = 16'h0456, ret, push_a, pcv, tab;
    logic global_int_enable, trp, push;
    int err_total = 0, cmp_count = 0, acks = 0, i;
    logic [7:0] slot [13] = '{8'hFA, 8'hF8, 8'hF6, 8'hF4, 8'hF2, 8'hEE,
        8'hEC, 8'hEA, 8'hE8, 8'hE6, 8'hE4, 8'hE2, 8'hE0};
    always #25 clk = ~clk;
    always @(posedge clk)
        if (ack === 1'b1) acks++;
    via_core_model via_core_model_i (.sys_clk_in(clk), .rstn_in(rstn),
        .run_in(run), .skip_in(skip), .busy_in(busy),
        .instr_start_out(st), .instr_skip_out(sk), .ret_addr_out(ret));
    via_arbiter via_arbiter_i (.sys_clk_in(clk), .rstn_in(rstn),
        .src_event_in(src), .instr_start_in(st), .instr_skip_in(sk),
        .trap_opcode_in(strb[0]), .clear_trap_pending_instr_in(strb[1]),
        .return_from_interrupt_in(strb[2]),
        .vector_select_instr_in(strb[3]), .vis_pc_in(vpc),
        .ret_addr_in(ret), .pop_addr_in(pop), .vec_hi_byte_in(8'hB3),
        .vec_lo_byte_in(8'h10), .boot_rom_exec_in(boot),
        .psw_wr_in(strb[4]), .psw_gie_in(gie_w), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
        .reg_rdata_out(rdata), .ack_start_out(ack), .ack_busy_out(busy),
        .push_out(push), .push_addr_out(push_a), .pc_load_out(pl),
        .pc_value_out(pcv), .table_addr_out(tab),
        .global_int_enable_out(global_int_enable), .trap_pending_flag_out(trp));
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task results;
        if (err_total == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", n, e, s);
            err_total++;
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 chk("rdata", e, rdata);
    endtask : rd
    task pls(input logic [4:0] m, input logic [12:0] s);
        @(posedge clk);
        strb <= m;
        src <= s;
        @(posedge clk);
        strb <= 5'h00;
        src <= 13'h0000;
        #1;
    endtask : pls
    task vector_select_instr(input logic [15:0] pc, input logic [15:0] et);
        vpc <= pc;
        pls(5'h08, 13'h0000);
        chk("table_addr", {16'h0, et}, {16'h0, tab});
        chk("pc_value", 32'h3310, {16'h0, pcv});
        chk("pc_load", 32'h1, {31'h0, pl});
    endtask : vector_select_instr
    task quiet;
        acks = 0;
        repeat (16) @(posedge clk);
        #1 chk("acks", 32'h0, acks);
    endtask : quiet
    task wait_ack;
        i = 0;
        while (ack !== 1'b1 && i < 40)
        begin
            @(posedge clk);
            #1 i++;
        end
        if (ack !== 1'b1)
        begin
            err_total++;
            results;
        end
        chk("push_addr", {1'b1, 15'h0, ret}, {push, 15'h0, push_a});
        chk("gie", 32'h0, {31'h0, global_int_enable});
        repeat (6) @(posedge clk);
        #1 chk("pc_entry", {16'h1, ENTRY_ADDR}, {15'h0, pl, pcv});
    endtask : wait_ack
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        rd(REG_ENABLE, 32'h0);
        rd(REG_STATUS, 32'h0);
        rd(4'hC, 32'h0);
        wr(REG_PENDING, 32'h9);
        wr(REG_ENABLE, 32'h9);
        rd(REG_PENDING, 32'h9);
        run <= 1'b1;
        quiet;
        gie_w <= 1'b1;
        pls(5'h10, 13'h0000);
        wait_ack;
        run <= 1'b0;
        vector_select_instr(16'h01FF, 16'h02FA);
        wr(REG_PENDING, 32'h8);
        pls(5'h04, 13'h0000);
        chk("return_from_interrupt_pc", {16'h0003, pop}, {14'h0, global_int_enable, pl, pcv});
        run <= 1'b1;
        wait_ack;
        run <= 1'b0;
        vector_select_instr(16'h0123, 16'h01F4);
        rd(REG_PENDING, 32'h8);
        pls(5'h01, 13'h0000);
        chk("trap_flag", 32'h1, {31'h0, trp});
        vector_select_instr(16'h0123, 16'h01FE);
        pls(5'h10, 13'h0000);
        rd(REG_STATUS, 32'h3);
        run <= 1'b1;
        quiet;
        pls(5'h02, 13'h0000);
        chk("trap_clear", 32'h0, {31'h0, trp});
        boot <= 1'b1;
        quiet;
        chk("gie_kept", 32'h1, {31'h0, global_int_enable});
        // raise skip first so no start slips through unskipped
        skip <= 1'b1;
        repeat (2) @(posedge clk);
        boot <= 1'b0;
        quiet;
        skip <= 1'b0;
        wait_ack;
        run <= 1'b0;
        wr(REG_ENABLE, 32'h0);
        vector_select_instr(16'h0123, 16'h01E0);
        for (int k = 0; k < NUM_SRC; k++)
        begin
            wr(REG_PENDING, 32'h0);
            wr(REG_ENABLE, 32'h1 << k);
            pls(5'h00, 13'h1 << k);
            vector_select_instr(16'h0500, {8'h05, slot[k]});
        end
        results;
    end
endmodule : testbench
